// ---- rtl/sms_pkg.sv ----
/*
 * sms_pkg: constants shared by the supply monitor reset sequencer.
 * Assumes a single 25 MHz clock and an APB register bus with 32-bit data.
 */
package sms_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 25;            // pclk rate in MHz
    localparam int INIT_CYC      = 4;             // register initialisation phase
    localparam logic [15:0] SYNC_LAST = 16'h0002; // hold cycles before synced causes count
    localparam int WARM_US       = 64;            // oscillator warm-up time, us
    localparam int WARM_CYC      = WARM_US * CLK_MHZ;
    localparam int WDT_LIMIT_DEF = 65535;         // watchdog overflow count

    // ------------------------------------------------------------
    // detector level option codes
    // ------------------------------------------------------------
    localparam logic [1:0] OPT_LOW  = 2'h0;       // detect_option_low
    localparam logic [1:0] OPT_MID  = 2'h1;       // detect_option_mid
    localparam logic [1:0] OPT_HIGH = 2'h2;       // detect_option_high
    localparam logic [1:0] OPT_MAX  = 2'h3;       // detect_option_max

    // ------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PROGRAM_FLAG_REG   = 10'h086; // program_flag_reg
    localparam logic [9:0] IDX_CTRL    = 10'h080; // watchdog control
    localparam logic [9:0] IDX_STATUS  = 10'h081; // sequencer state and causes
    localparam logic [9:0] IDX_INT_ST  = 10'h082; // sticky event bits, write 1 clears
    localparam logic [9:0] IDX_INT_MSK = 10'h083; // event mask

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PF_FLAG_HIGH = 5;              // low_supply_flag_high
    localparam int PF_FLAG_MID  = 4;              // low_supply_flag_mid
    localparam int CT_WDT_EN    = 0;              // watchdog enable
    localparam int CT_WDT_CLR   = 1;              // watchdog clear, write 1
    localparam int NUM_EV       = 5;              // interrupt event count
    localparam int EV_DROOP     = 0;              // detector reset
    localparam int EV_WDT       = 1;              // watchdog reset
    localparam int EV_PIN       = 2;              // external pin reset
    localparam int EV_MID       = 3;              // mid flag rose
    localparam int EV_HIGH      = 4;              // high flag rose

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       CTRL_WDT_EN_RST = 1'h1;
    localparam logic [4:0] INT_MSK_RST     = 5'h00;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_INIT,
        ST_WARM,
        ST_RUN
    } sms_state_type;

endpackage

// ---- rtl/sms_sync.sv ----
/*
 * sms_sync: two-flop synchroniser, one per bit.
 * Assumes the inputs are asynchronous levels; the output is clean on pclk.
 */
module sms_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // per bit: first stage feeds only the second stage
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic meta_q;                  // first stage, read by nothing else
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    meta_q        <= 1'b0;
                    sync_out[gi]  <= 1'b0;
                end
                else
                begin
                    meta_q        <= async_in[gi];
                    sync_out[gi]  <= meta_q;
                end
            end
        end
    endgenerate

endmodule

// ---- rtl/sms_reset_seq.sv ----
/*
 * sms_reset_seq: supply monitor and system reset sequencer with APB registers.
 * Assumes analog comparators and the reset pin are asynchronous to pclk, the
 * option straps are stable from power-up, and the core honours sys_reset_n.
 */
// Behaviour
// - low option: reset below 2.0V, flags off
// - flags at bits 5,4 of 086H, read-only
// - mid option resets below 2.0V
// - mid option drives 2.4V flag
// - mid option keeps 3.6V flag off
// - high option resets below 2.4V
// - high option drives 2.4V flag (never set here: droop_s clears the flag whenever s_2v4 is high)
// - high option drives 3.6V flag
// - max option resets below 3.6V
// - detector reset clears both flags
// - watchdog overflow forces full reset
// - pin resets only when option enables it
// - enabled pin is active low
// - sequence waits for pin release
// - init, warm-up, then fetch at zero
// - every source runs the full sequence
module sms_reset_seq
    import sms_pkg::*;
#(
    parameter int WDT_LIMIT = sms_pkg::WDT_LIMIT_DEF
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // supply comparators, high while supply is at or below the level
    input  wire logic        below_2v0,
    input  wire logic        below_2v4,
    input  wire logic        below_3v6,
    // external reset pin and static straps
    input  wire logic        ext_reset_n,
    input  wire logic        reset_pin_enable,
    input  wire logic [1:0]  detect_option,
    // to the core
    output logic             sys_reset_n,
    output logic             reg_init,
    output logic             fetch_start,
    output logic [15:0]      fetch_addr,
    output logic             irq
);
    import sms_pkg::*;

    // ------------------------------------------------------------
    // last-cycle counts, warm-up derived from the clock rate
    // ------------------------------------------------------------
    localparam logic [15:0] WARM_LAST = 16'(WARM_CYC - 1);
    localparam logic [15:0] INIT_LAST = 16'(INIT_CYC - 1);
    localparam logic [15:0] WDT_LAST  = 16'(WDT_LIMIT - 1);

    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    logic [3:0]    sync_q;                 // 2v0, 2v4, 3v6, pin
    logic          s_2v0;
    logic          s_2v4;
    logic          s_3v6;
    logic          s_pin_n;

    sms_sync #(.WIDTH(4)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({below_2v0, below_2v4, below_3v6, ext_reset_n}),
        .sync_out (sync_q)
    );

    assign s_2v0   = sync_q[3];
    assign s_2v4   = sync_q[2];
    assign s_3v6   = sync_q[1];
    assign s_pin_n = sync_q[0];

    // ------------------------------------------------------------
    // straps, captured while the system is held in reset
    // ------------------------------------------------------------
    logic [1:0]    opt_q;                  // latched detector option
    logic          pin_en_q;               // latched reset pin option
    sms_state_type state_q;
    sms_state_type state_d;

    // only sampled in hold so a stray change during run is ignored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_q    <= OPT_LOW;
            pin_en_q <= 1'b0;
        end
        else if (state_q == ST_HOLD)
        begin
            opt_q    <= detect_option;
            pin_en_q <= reset_pin_enable;
        end
    end

    // ------------------------------------------------------------
    // reset causes: raw for assertion, synced for release
    // ------------------------------------------------------------
    logic          droop_raw;              // detector level crossed, async
    logic          pin_raw;                // enabled pin low, async
    logic          droop_s;                // detector level crossed, synced
    logic          pin_s;                  // enabled pin low, synced
    logic          wdt_ovf;                // watchdog overflow this cycle
    logic          any_s;                  // any synced cause

    // higher options include the lower levels so a deep droop still resets
    assign droop_raw = below_2v0
                     | (below_2v4 & (opt_q == OPT_HIGH))
                     | ((below_2v4 | below_3v6) & (opt_q == OPT_MAX));
    assign droop_s   = s_2v0
                     | (s_2v4 & (opt_q == OPT_HIGH))
                     | ((s_2v4 | s_3v6) & (opt_q == OPT_MAX));
    assign pin_raw   = pin_en_q & ~ext_reset_n;
    assign pin_s     = pin_en_q & ~s_pin_n;
    assign any_s     = droop_s | pin_s | wdt_ovf;

    // ------------------------------------------------------------
    // sequencer: hold, init, warm-up, run
    // ------------------------------------------------------------
    logic [15:0]   cnt_q;                  // phase counter
    logic          cnt_done;

    assign cnt_done = (state_q == ST_INIT) ? (cnt_q == INIT_LAST)
                                           : (cnt_q == WARM_LAST);

    // any cause from any state restarts the whole sequence
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_HOLD:
                if (!droop_s && !pin_s && cnt_q >= SYNC_LAST)
                    state_d = ST_INIT;
            ST_INIT:
                if (cnt_done)
                    state_d = ST_WARM;
            ST_WARM:
                if (cnt_done)
                    state_d = ST_RUN;
            ST_RUN:
                state_d = ST_RUN;
            default:
                state_d = ST_HOLD;
        endcase
        if (any_s)
            state_d = ST_HOLD;
    end

    // state register and phase counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_HOLD;
            cnt_q   <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= (state_d != state_q) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // assertion is asynchronous; release only via the synced sequence
    assign sys_reset_n = (state_q == ST_RUN) & ~droop_raw & ~pin_raw;
    assign reg_init    = (state_q == ST_INIT);
    assign fetch_addr  = 16'h0000;

    // one-cycle pulse as run begins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fetch_start <= 1'b0;
        else
            fetch_start <= (state_q == ST_WARM) && (state_d == ST_RUN);
    end

    // ------------------------------------------------------------
    // watchdog: counts in run until software clears it
    // ------------------------------------------------------------
    logic [15:0]   wdt_q;                  // watchdog count
    logic          wdt_en_q;               // enable bit
    logic          wdt_clr;                // software clear strobe

    assign wdt_ovf = wdt_en_q & (state_q == ST_RUN) & (wdt_q == WDT_LAST);

    // stopped outside run so a slow sequence cannot trip it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdt_q <= 16'h0000;
        else if (state_q != ST_RUN || wdt_clr || wdt_ovf || !wdt_en_q)
            wdt_q <= 16'h0000;
        else
            wdt_q <= wdt_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // supply level flags
    // ------------------------------------------------------------
    logic          flag_mid_q;             // low_supply_flag_mid
    logic          flag_high_q;            // low_supply_flag_high
    logic          mid_act;
    logic          high_act;

    assign mid_act  = (opt_q == OPT_MID) | (opt_q == OPT_HIGH);
    assign high_act = (opt_q == OPT_HIGH);

    // flags follow the comparators only while running
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_mid_q  <= 1'b0;
            flag_high_q <= 1'b0;
        end
        else if (state_q != ST_RUN || droop_s)
        begin
            flag_mid_q  <= 1'b0;
            flag_high_q <= 1'b0;
        end
        else
        begin
            flag_mid_q  <= mid_act & s_2v4;
            flag_high_q <= high_act & s_3v6;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [9:0]    idx;
    logic          wr_en;
    logic          hit_program_flag_reg;
    logic          hit_ctrl;
    logic          hit_stat;
    logic          hit_ist;
    logic          hit_msk;
    logic          hit_any;

    assign idx       = paddr[11:2];
    assign hit_program_flag_reg = (idx == IDX_PROGRAM_FLAG_REG);
    assign hit_ctrl  = (idx == IDX_CTRL);
    assign hit_stat  = (idx == IDX_STATUS);
    assign hit_ist   = (idx == IDX_INT_ST);
    assign hit_msk   = (idx == IDX_INT_MSK);
    assign hit_any   = hit_program_flag_reg | hit_ctrl | hit_stat | hit_ist | hit_msk;
    assign wr_en     = psel & penable & pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~hit_any;
    assign wdt_clr   = wr_en & hit_ctrl & pwdata[CT_WDT_CLR];

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic [NUM_EV-1:0] ev;                 // one-cycle events
    logic [NUM_EV-1:0] ist_q;              // sticky status
    logic [NUM_EV-1:0] msk_q;              // mask, 1 enables
    logic [NUM_EV-1:0] ist_clr;
    logic              mid_d1_q;
    logic              high_d1_q;
    logic              hold_d1_q;          // next state was hold last cycle

    // causes are counted once, on entry to hold
    assign ev[EV_DROOP] = droop_s & ~hold_d1_q;
    assign ev[EV_WDT]   = wdt_ovf;
    assign ev[EV_PIN]   = pin_s & ~droop_s & ~hold_d1_q;
    assign ev[EV_MID]   = flag_mid_q & ~mid_d1_q;
    assign ev[EV_HIGH]  = flag_high_q & ~high_d1_q;
    assign ist_clr      = (wr_en & hit_ist) ? pwdata[NUM_EV-1:0] : '0;
    assign irq          = |(ist_q & msk_q);

    // set beats a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ist_q     <= '0;
            msk_q     <= INT_MSK_RST;
            wdt_en_q  <= CTRL_WDT_EN_RST;
            mid_d1_q  <= 1'b0;
            high_d1_q <= 1'b0;
            hold_d1_q <= 1'b1;
        end
        else
        begin
            ist_q     <= (ist_q & ~ist_clr) | ev;
            mid_d1_q  <= flag_mid_q;
            high_d1_q <= flag_high_q;
            hold_d1_q <= (state_d == ST_HOLD);
            if (wr_en && hit_msk)
                msk_q <= pwdata[NUM_EV-1:0];
            if (wr_en && hit_ctrl)
                wdt_en_q <= pwdata[CT_WDT_EN];
        end
    end

    // ------------------------------------------------------------
    // read data, registered in the setup cycle
    // ------------------------------------------------------------
    logic [31:0]   rd_mux;

    assign rd_mux = hit_program_flag_reg ? {26'h0, flag_high_q, flag_mid_q, 4'h0} :
                    hit_ctrl  ? {31'h0, wdt_en_q} :
                    hit_stat  ? {24'h0, pin_en_q, opt_q, s_pin_n,
                                 droop_s, 1'b0, state_q} :
                    hit_ist   ? {27'h0, ist_q} :
                    hit_msk   ? {27'h0, msk_q} : 32'h0000_0000;

    // data settles before the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

endmodule

// ---- tb/sms_ext_reset_model.sv ----
/*
 * external reset circuit on the active-low reset pin.
 * Assumes hold_low changes at pclk edges; rise_cyc is a slow RC release.
 */
module sms_ext_reset_model (
    // clock
    input  wire logic       pclk,
    // commands from the bench
    input  wire logic       hold_low,
    input  wire logic [7:0] rise_cyc,
    // reset pin, pulled up
    output logic            ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rise_q = 8'h00;  // cycles left before the pin reaches high

    // --------------------------------------------------------------
    // slow release
    // --------------------------------------------------------------
    always_ff @(posedge pclk)
    begin
        if (hold_low)
            rise_q <= rise_cyc;
        else if (rise_q != 8'h00)
            rise_q <= rise_q - 8'h01;
    end

    // pin sits high unless a reset is commanded or still rising
    assign ext_reset_n = !(hold_low || rise_q != 8'h00);
endmodule

// ---- tb/sms_reset_seq_monitor.sv ----
/*
 * concurrent checks on the sequencer's ports.
 * Assumes a bind into sms_reset_seq.
 */
module sms_reset_seq_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pslverr,
    // causes and straps
    input wire logic        below_2v0,
    input wire logic        below_2v4,
    input wire logic        below_3v6,
    input wire logic        ext_reset_n,
    input wire logic        reset_pin_enable,
    input wire logic [1:0]  detect_option,
    // core side
    input wire logic        sys_reset_n,
    input wire logic        reg_init,
    input wire logic        fetch_start,
    input wire logic [15:0] fetch_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import sms_pkg::*;

    // --------------------------------------------------------------
    // helper: cycles since initialisation ended, saturating
    // --------------------------------------------------------------
    logic [11:0] warm_q;   // counted warm-up cycles
    logic [11:0] warm_d;   // next count
    wire         mapped;   // address hits a register

    assign warm_d = reg_init ? 12'h000 : (warm_q == 12'hFFF) ? warm_q : warm_q + 12'h001;
    assign mapped = paddr[11:2] inside {IDX_PROGRAM_FLAG_REG, IDX_CTRL, IDX_STATUS, IDX_INT_ST, IDX_INT_MSK};

    // counter restarts with every initialisation phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            warm_q <= 12'h000;
        else
            warm_q <= warm_d;
    end

    default clocking mon_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_PIN_RESET: assert property (reset_pin_enable && !ext_reset_n |-> !sys_reset_n)
        else $error("pin low without reset");
    AST_DROOP_2V0: assert property (below_2v0 |-> !sys_reset_n)
        else $error("low level missed");
    AST_DROOP_2V4: assert property (detect_option == OPT_HIGH && below_2v4 |-> !sys_reset_n)
        else $error("mid level missed");
    AST_DROOP_3V6: assert property (detect_option == OPT_MAX && below_3v6 |-> !sys_reset_n)
        else $error("top level missed");
    AST_INIT_LEN: assert property ($rose(reg_init) |-> reg_init [*4] ##1 !reg_init)
        else $error("init length wrong");
    AST_INIT_HELD: assert property (reg_init |-> !sys_reset_n && !fetch_start)
        else $error("core run in init");
    AST_WARM_FETCH: assert property (fetch_start |-> warm_q == WARM_CYC && sys_reset_n
        && fetch_addr == 16'h0000)
        else $error("fetch too early");
    AST_FETCH_PULSE: assert property (fetch_start |=> !fetch_start)
        else $error("fetch pulse too long");
    AST_SEQ_FULL: assert property ($fell(sys_reset_n) |-> !sys_reset_n [*8])
        else $error("reset too short");
    AST_PROGRAM_FLAG_REG_MAP: assert property (psel && penable && paddr[11:2] == IDX_PROGRAM_FLAG_REG |-> !pslverr)
        else $error("flag access refused");
    AST_UNMAPPED: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped not refused");
endmodule

bind sms_reset_seq sms_reset_seq_monitor i_mon (.pclk, .presetn, .psel, .penable, .paddr,
    .pslverr, .below_2v0, .below_2v4, .below_3v6, .ext_reset_n, .reset_pin_enable,
    .detect_option, .sys_reset_n, .reg_init, .fetch_start, .fetch_addr);

// ---- tb/sms_reset_seq_supply_monitor_reset_sequencer_bench.sv ----
/*
 * self-checking bench of sms_reset_seq.
 * Assumes the reset pin model and a short watchdog count.
 */
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, got, exp); end end
module supply_monitor_reset_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import sms_pkg::*;

    localparam int WDT_SIM = 20;  // short watchdog keeps the run brief

    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic pready, pslverr, rd_err, irq, sys_reset_n, reg_init, fetch_start, ext_reset_n;
    logic below_2v0 = 1'b0, below_2v4 = 1'b0, below_3v6 = 1'b0;
    logic reset_pin_enable = 1'b0, pin_hold = 1'b0;
    logic [1:0] detect_option = OPT_LOW;
    logic [7:0] pin_rise = 8'h00;
    logic [15:0] fetch_addr;
    int n_mismatch = 0, num_checks = 0;

    always #20 pclk = ~pclk;

    sms_reset_seq #(.WDT_LIMIT(WDT_SIM)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .below_2v0, .below_2v4, .below_3v6,
        .ext_reset_n, .reset_pin_enable, .detect_option, .sys_reset_n, .reg_init,
        .fetch_start, .fetch_addr, .irq);
    sms_ext_reset_model i_pin (.pclk, .hold_low(pin_hold), .rise_cyc(pin_rise), .ext_reset_n);

    // --------------------------------------------------------------
    // apb master: setup, access until pready, then release
    // --------------------------------------------------------------
    task automatic apb_xfer(input logic wr, input logic [9:0] i, input logic [31:0] wd = 32'h0);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {i, 2'b00}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // straps change only while the chip is held in power-on reset
    task automatic power_up(input logic [1:0] opt, input logic pin_en);
        @(posedge pclk);
        presetn <= 1'b0; detect_option <= opt; reset_pin_enable <= pin_en;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // wait for the fetch pulse, then set watchdog control at once
    task automatic wait_fetch(input logic [31:0] ctrl);
        for (int n = 0; n < 4000 && fetch_start !== 1'b1; n++)
            @(posedge pclk);
        `CHK(fetch_start, 1'b1)
        `CHK(fetch_addr, 16'h0000)
        apb_xfer(1'b1, IDX_CTRL, ctrl);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    // each option against up to three falling supply steps, stopping at the one that resets it
    task automatic scen_levels();
        int thr;
        logic [1:0] expf;
        for (int opt = 0; opt < 4; opt++)
        begin
            thr = (opt == 3) ? 0 : (opt == 2) ? 1 : 2;
            power_up(opt[1:0], 1'b0);
            wait_fetch(32'h0);
            for (int p = 0; p < 3; p++)
            begin
                @(posedge pclk);
                below_3v6 <= 1'b1; below_2v4 <= (p > 0); below_2v0 <= (p > 1);
                repeat (4) @(posedge pclk);
                `CHK(sys_reset_n, logic'(p < thr))
                if (p < thr)
                begin
                    expf = {opt == 2, (opt == 1 || opt == 2) && p > 0};
                    apb_xfer(1'b0, IDX_PROGRAM_FLAG_REG);
                    `CHK(rd_data[5:4], expf)
                end
                else
                begin
                    // top comparator stays high, flags must still read clear
                    @(posedge pclk);
                    below_2v0 <= 1'b0; below_2v4 <= 1'b0;
                    apb_xfer(1'b0, IDX_PROGRAM_FLAG_REG);
                    `CHK(rd_data[5:4], 2'b00)
                    apb_xfer(1'b0, IDX_INT_ST);
                    `CHK(rd_data[EV_DROOP], 1'b1)
                    apb_xfer(1'b1, IDX_INT_ST, 32'h1F);
                    @(posedge pclk);
                    below_3v6 <= 1'b0;
                    wait_fetch(32'h0);
                    break;
                end
            end
        end
    endtask

    // pin low at power-up, slow release in run, then strap off
    task automatic scen_pin();
        @(posedge pclk);
        pin_hold <= 1'b1;
        power_up(OPT_LOW, 1'b1);
        repeat (40) @(posedge pclk);
        `CHK(sys_reset_n, 1'b0)
        `CHK(reg_init, 1'b0)
        pin_hold <= 1'b0;
        wait_fetch(32'h0);
        @(posedge pclk);
        pin_rise <= 8'h10; pin_hold <= 1'b1;
        @(posedge pclk);
        `CHK(sys_reset_n, 1'b0)
        pin_hold <= 1'b0;
        repeat (12) @(posedge pclk);
        `CHK(sys_reset_n, 1'b0)
        wait_fetch(32'h0);
        apb_xfer(1'b0, IDX_INT_ST);
        `CHK(rd_data[EV_PIN], 1'b1)
        power_up(OPT_LOW, 1'b0);
        wait_fetch(32'h0);
        pin_hold <= 1'b1;
        repeat (20) @(posedge pclk);
        `CHK(sys_reset_n, 1'b1)
        pin_hold <= 1'b0; pin_rise <= 8'h00;
    endtask

    // watchdog cleared in time, then left to overflow; its interrupt
    task automatic scen_wdt();
        power_up(OPT_LOW, 1'b0);
        wait_fetch(32'h3);
        repeat (4)
        begin
            repeat (8) @(posedge pclk);
            apb_xfer(1'b1, IDX_CTRL, 32'h3);
            `CHK(sys_reset_n, 1'b1)
        end
        for (int n = 0; n < 40 && sys_reset_n !== 1'b0; n++)
            @(posedge pclk);
        `CHK(sys_reset_n, 1'b0)
        wait_fetch(32'h0);
        apb_xfer(1'b0, IDX_INT_MSK);
        `CHK(rd_data[4:0], INT_MSK_RST)
        apb_xfer(1'b0, IDX_INT_ST);
        `CHK(rd_data[EV_WDT], 1'b1)
        `CHK(irq, 1'b0)
        apb_xfer(1'b1, IDX_INT_MSK, 32'h2);
        @(posedge pclk);
        `CHK(irq, 1'b1)
        apb_xfer(1'b1, IDX_INT_MSK, 32'h0);
        @(posedge pclk);
        `CHK(irq, 1'b0)
        apb_xfer(1'b1, IDX_INT_MSK, 32'h2);
        apb_xfer(1'b1, IDX_INT_ST, 32'h2);
        @(posedge pclk);
        `CHK(irq, 1'b0)
    endtask

    // unmapped access and read-only flags
    task automatic scen_regs();
        power_up(OPT_MID, 1'b0);
        wait_fetch(32'h0);
        apb_xfer(1'b0, 10'h000);
        `CHK(rd_err, 1'b1)
        `CHK(rd_data, 32'h00000000)
        below_2v4 <= 1'b1;
        apb_xfer(1'b1, IDX_PROGRAM_FLAG_REG);
        apb_xfer(1'b0, IDX_PROGRAM_FLAG_REG);
        `CHK(rd_data[5:4], 2'b01)
        below_2v4 <= 1'b0;
        apb_xfer(1'b1, IDX_PROGRAM_FLAG_REG, 32'h30);
        apb_xfer(1'b0, IDX_PROGRAM_FLAG_REG);
        `CHK(rd_data[5:4], 2'b00)
        apb_xfer(1'b0, IDX_STATUS);
        `CHK(rd_data[1:0], 2'h3)
    endtask

    // --------------------------------------------------------------
    // verdict
    // --------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard: the sequence needs about 23k cycles
    initial
    begin
        #2000000;
        n_mismatch++;
        complete_run();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        scen_levels();
        scen_pin();
        scen_wdt();
        scen_regs();
        complete_run();
    end
endmodule
